// ---- core/sfpt_pkg.sv ----
// Constants for the serial flash parameter table block
package sfpt_pkg;
  localparam int ADDR_W = 8;
  // Word register offsets (byte addresses)
  localparam logic [7:0] OFF_CAP_DWORD_ONE = 8'h00;
  localparam logic [7:0] OFF_DENSITY_DWORD = 8'h04;
  localparam logic [7:0] OFF_QUAD_READ_CYCLES_DWORD = 8'h08;
  localparam logic [7:0] OFF_DUAL_READ_CYCLES_DWORD = 8'h0C;
  localparam logic [7:0] OFF_FAST_MODE_SUPPORT_BYTE = 8'h10;
  localparam logic [7:0] OFF_HEADER = 8'h14;
  localparam logic [7:0] OFF_BYTE_PTR = 8'h20;
  localparam logic [7:0] OFF_BYTE_DATA = 8'h24;
  localparam logic [7:0] OFF_LIST_OFFSET = 8'h28;
  localparam logic [7:0] OFF_SPACE_ADDR = 8'h2C;
  // Parameter header bytes, table base address and list offset skew
  localparam logic [7:0] PARAM_ID = 8'hA5;
  localparam logic [7:0] PARAM_LEN = 8'h80;
  localparam logic [15:0] TABLE_BASE = 16'h1090;
  localparam logic [8:0] LIST_SKEW = 9'h002;
  // Table dwords; dword one carries the DDR flag added separately
  localparam logic [31:0] DW1_BASE = 32'hFFB2_FFE7;
  localparam int DW1_DDR_BIT = 19;
  localparam logic [31:0] DW2_VAL = 32'h3FFF_FFFF;
  localparam logic [31:0] DW3_VAL = 32'hFFFF_EB48;
  localparam logic [31:0] DW4_VAL = 32'hBB88_FFFF;
  localparam logic [31:0] DW5_VAL = 32'hFFFF_FFFE;
  localparam logic [31:0] FILL_ONES = 32'hFFFF_FFFF;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// ---- core/sfpt_table.sv ----
// Serial flash basic parameter table with register port
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module sfpt_table #(
  parameter bit DDR_SUPPORTED = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [sfpt_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);

  typedef struct packed {
    logic [7:0] ptr;
    logic [31:0] rdata;
  } sfpt_state_t;

  sfpt_state_t state_reg;
  sfpt_state_t state_next;
  logic [31:0] dw1_val;
  logic [7:0] cur_byte;
  logic [31:0] cur_word;

  assign dw1_val = sfpt_pkg::DW1_BASE | (32'(DDR_SUPPORTED) << sfpt_pkg::DW1_DDR_BIT);

  function automatic logic [31:0] dword_at(input logic [5:0] sel, input logic [31:0] d1);
    logic [31:0] w;
    w = sfpt_pkg::FILL_ONES;
    unique case (sel)
      6'd0: w = d1;
      6'd1: w = sfpt_pkg::DW2_VAL;
      6'd2: w = sfpt_pkg::DW3_VAL;
      6'd3: w = sfpt_pkg::DW4_VAL;
      6'd4: w = sfpt_pkg::DW5_VAL;
      default: w = sfpt_pkg::FILL_ONES;
    endcase
    return w;
  endfunction

  // Least significant byte first within each dword
  assign cur_word = dword_at(state_reg.ptr[7:2], dw1_val);
  assign cur_byte = cur_word[8*state_reg.ptr[1:0] +: 8];

  always_comb
  begin
    state_next = state_reg;
    state_next.rdata = 32'h0000_0000;
    if (wr && addr == sfpt_pkg::OFF_BYTE_PTR)
    begin
      state_next.ptr = wdata[7:0];
    end
    if (rd)
    begin
      unique case (addr)
        sfpt_pkg::OFF_CAP_DWORD_ONE: state_next.rdata = dw1_val;
        sfpt_pkg::OFF_DENSITY_DWORD: state_next.rdata = sfpt_pkg::DW2_VAL;
        sfpt_pkg::OFF_QUAD_READ_CYCLES_DWORD: state_next.rdata = sfpt_pkg::DW3_VAL;
        sfpt_pkg::OFF_DUAL_READ_CYCLES_DWORD: state_next.rdata = sfpt_pkg::DW4_VAL;
        sfpt_pkg::OFF_FAST_MODE_SUPPORT_BYTE: state_next.rdata = {24'h00_0000, sfpt_pkg::DW5_VAL[7:0]};
        sfpt_pkg::OFF_HEADER: state_next.rdata = {16'h0000, sfpt_pkg::PARAM_LEN, sfpt_pkg::PARAM_ID};
        sfpt_pkg::OFF_BYTE_PTR: state_next.rdata = {24'h00_0000, state_reg.ptr};
        sfpt_pkg::OFF_BYTE_DATA:
        begin
          // Each byte read advances so the host streams the table
          state_next.rdata = {24'h00_0000, cur_byte};
          state_next.ptr = state_reg.ptr + 8'h01;
        end
        sfpt_pkg::OFF_LIST_OFFSET: state_next.rdata = {23'h00_0000, {1'b0, state_reg.ptr} + sfpt_pkg::LIST_SKEW};
        sfpt_pkg::OFF_SPACE_ADDR: state_next.rdata = {16'h0000, sfpt_pkg::TABLE_BASE + {8'h00, state_reg.ptr}};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg.ptr <= sfpt_pkg::PTR_RESET;
      state_reg.rdata <= sfpt_pkg::RDATA_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_hdr_id;
    rd && addr == sfpt_pkg::OFF_HEADER |=> rdata[7:0] == 8'hA5;
  endproperty
  a_hdr_id: assert property (p_hdr_id) else $error("header id wrong");

  property p_hdr_len;
    rd && addr == sfpt_pkg::OFF_HEADER |=> rdata[15:8] == 8'h80 && rdata[31:16] == 16'h0000;
  endproperty
  a_hdr_len: assert property (p_hdr_len) else $error("header length wrong");

  property p_space;
    rd && addr == sfpt_pkg::OFF_SPACE_ADDR |=> rdata == 32'h0000_1090 + {24'h00_0000, $past(state_reg.ptr)};
  endproperty
  a_space: assert property (p_space) else $error("space address wrong");

  property p_dw1;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE |=> rdata[7:0] == 8'hE7 && rdata[15:8] == 8'hFF
      && rdata[31:24] == 8'hFF && rdata[22:20] == 3'b011 && rdata[18:16] == 3'b010 && rdata[19] == DDR_SUPPORTED;
  endproperty
  a_dw1: assert property (p_dw1) else $error("dword one wrong");

  property p_dw2;
    rd && addr == sfpt_pkg::OFF_DENSITY_DWORD |=> rdata == 32'h3FFF_FFFF;
  endproperty
  a_dw2: assert property (p_dw2) else $error("density wrong");

  property p_dw3;
    rd && addr == sfpt_pkg::OFF_QUAD_READ_CYCLES_DWORD |=> rdata == 32'hFFFF_EB48;
  endproperty
  a_dw3: assert property (p_dw3) else $error("quad read dword wrong");

  property p_dw4;
    rd && addr == sfpt_pkg::OFF_DUAL_READ_CYCLES_DWORD |=> rdata == 32'hBB88_FFFF;
  endproperty
  a_dw4: assert property (p_dw4) else $error("dual read dword wrong");

  property p_dw5;
    rd && addr == sfpt_pkg::OFF_FAST_MODE_SUPPORT_BYTE |=> rdata == 32'h0000_00FE;
  endproperty
  a_dw5: assert property (p_dw5) else $error("fast mode byte wrong");

  property p_seq;
    rd && addr == sfpt_pkg::OFF_BYTE_DATA ##1 rd && addr == sfpt_pkg::OFF_BYTE_DATA
      |-> state_reg.ptr == $past(state_reg.ptr) + 8'h01;
  endproperty
  a_seq: assert property (p_seq) else $error("byte pointer did not advance");

  property p_lsb_first;
    rd && addr == sfpt_pkg::OFF_BYTE_DATA && state_reg.ptr == 8'h02
      |=> rdata[7:0] == (DDR_SUPPORTED ? 8'hBA : 8'hB2);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("byte order wrong");

  property p_list;
    rd && addr == sfpt_pkg::OFF_LIST_OFFSET |=> rdata == {24'h00_0000, $past(state_reg.ptr)} + 32'h0000_0002;
  endproperty
  a_list: assert property (p_list) else $error("list offset wrong");

  // Field checks on dword one
  property p_dw1_erase;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE
      |=> rdata[1:0] == 2'b11 && rdata[15:8] == 8'hFF;
  endproperty
  a_dw1_erase: assert property (p_dw1_erase) else $error("uniform erase field wrong");

  property p_dw1_wren;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE
      |=> rdata[4:3] == 2'b00 && rdata[2] == 1'b1;
  endproperty
  a_dw1_wren: assert property (p_dw1_wren) else $error("write enable field wrong");

  property p_dw1_unused;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE
      |=> rdata[7:5] == 3'b111;
  endproperty
  a_dw1_unused: assert property (p_dw1_unused) else $error("unused bits not ones");

  property p_dw1_reads;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE
      |=> rdata[21] && rdata[20] && !rdata[22] && !rdata[16];
  endproperty
  a_dw1_reads: assert property (p_dw1_reads) else $error("read support flags wrong");

  property p_dw1_addr;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE
      |=> rdata[18:17] == 2'b01;
  endproperty
  a_dw1_addr: assert property (p_dw1_addr) else $error("address bytes field wrong");

  property p_dw1_ddr;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE
      |=> rdata[19] == DDR_SUPPORTED;
  endproperty
  a_dw1_ddr: assert property (p_dw1_ddr) else $error("ddr flag wrong");

  property p_dw1_top;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE
      |=> rdata[31:24] == 8'hFF;
  endproperty
  a_dw1_top: assert property (p_dw1_top) else $error("top byte not ones");

  property p_dw1_bit23;
    rd && addr == sfpt_pkg::OFF_CAP_DWORD_ONE
      |=> rdata[23] == 1'b1;
  endproperty
  a_dw1_bit23: assert property (p_dw1_bit23) else $error("unused bit not one");

  // Density dword
  property p_dw2_msb;
    rd && addr == sfpt_pkg::OFF_DENSITY_DWORD
      |=> rdata[31:24] == 8'h3F;
  endproperty
  a_dw2_msb: assert property (p_dw2_msb) else $error("density top byte wrong");

  property p_dw2_low;
    rd && addr == sfpt_pkg::OFF_DENSITY_DWORD
      |=> rdata[23:0] == 24'hFF_FFFF;
  endproperty
  a_dw2_low: assert property (p_dw2_low) else $error("density low bytes wrong");

  // Multi-I/O read encodings
  property p_quad_cyc;
    rd && addr == sfpt_pkg::OFF_QUAD_READ_CYCLES_DWORD
      |=> rdata[7:5] == 3'b010 && rdata[4:0] == 5'b01000;
  endproperty
  a_quad_cyc: assert property (p_quad_cyc) else $error("quad io cycles wrong");

  property p_quad_op;
    rd && addr == sfpt_pkg::OFF_QUAD_READ_CYCLES_DWORD
      |=> rdata[15:8] == 8'hEB;
  endproperty
  a_quad_op: assert property (p_quad_op) else $error("quad io opcode wrong");

  property p_qout;
    rd && addr == sfpt_pkg::OFF_QUAD_READ_CYCLES_DWORD
      |=> rdata[23:21] == 3'b111 && rdata[20:16] == 5'b11111 && rdata[31:24] == 8'hFF;
  endproperty
  a_qout: assert property (p_qout) else $error("quad output not absent");

  property p_dout;
    rd && addr == sfpt_pkg::OFF_DUAL_READ_CYCLES_DWORD
      |=> rdata[7:5] == 3'b111 && rdata[4:0] == 5'b11111 && rdata[15:8] == 8'hFF;
  endproperty
  a_dout: assert property (p_dout) else $error("dual output not absent");

  property p_dual_cyc;
    rd && addr == sfpt_pkg::OFF_DUAL_READ_CYCLES_DWORD
      |=> rdata[23:21] == 3'b100 && rdata[20:16] == 5'b01000;
  endproperty
  a_dual_cyc: assert property (p_dual_cyc) else $error("dual io cycles wrong");

  property p_dual_op;
    rd && addr == sfpt_pkg::OFF_DUAL_READ_CYCLES_DWORD
      |=> rdata[31:24] == 8'hBB;
  endproperty
  a_dual_op: assert property (p_dual_op) else $error("dual io opcode wrong");

  property p_fast_bits;
    rd && addr == sfpt_pkg::OFF_FAST_MODE_SUPPORT_BYTE
      |=> rdata[4] && !rdata[0] && rdata[7:5] == 3'b111 && rdata[3:1] == 3'b111;
  endproperty
  a_fast_bits: assert property (p_fast_bits) else $error("fast mode bits wrong");

  // Read port behaviour
  property p_idle_zero;
    !rd
      |=> rdata == 32'h0000_0000;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not cleared");

  property p_unmapped;
    rd && addr > sfpt_pkg::OFF_SPACE_ADDR
      |=> rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Byte pointer
  property p_ptr_write;
    wr && addr == sfpt_pkg::OFF_BYTE_PTR
      |=> state_reg.ptr == $past(wdata[7:0]);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

  property p_ptr_hold;
    !(wr && addr == sfpt_pkg::OFF_BYTE_PTR) && !(rd && addr == sfpt_pkg::OFF_BYTE_DATA)
      |=> $stable(state_reg.ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved unasked");

  property p_ptr_adv;
    rd && addr == sfpt_pkg::OFF_BYTE_DATA
      |=> state_reg.ptr == $past(state_reg.ptr) + 8'h01;
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not step");

  property p_ptr_wrap;
    rd && addr == sfpt_pkg::OFF_BYTE_DATA && state_reg.ptr == 8'hFF
      |=> state_reg.ptr == 8'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  property p_ptr_read;
    rd && addr == sfpt_pkg::OFF_BYTE_PTR
      |=> rdata == {24'h00_0000, $past(state_reg.ptr)};
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer readback wrong");

  property p_list_high;
    rd && addr == sfpt_pkg::OFF_LIST_OFFSET && state_reg.ptr == 8'hFF
      |=> rdata == 32'h0000_0101;
  endproperty
  a_list_high: assert property (p_list_high) else $error("list offset carry lost");

  property p_space_high;
    rd && addr == sfpt_pkg::OFF_SPACE_ADDR && state_reg.ptr == 8'hFF
      |=> rdata == 32'h0000_118F;
  endproperty
  a_space_high: assert property (p_space_high) else $error("space address top wrong");

  // Byte stream
  property p_fill;
    rd && addr == sfpt_pkg::OFF_BYTE_DATA && state_reg.ptr >= 8'h14
      |=> rdata == 32'h0000_00FF;
  endproperty
  a_fill: assert property (p_fill) else $error("unused table byte not ones");

  property p_byte_upper;
    rd && addr == sfpt_pkg::OFF_BYTE_DATA
      |=> rdata[31:8] == 24'h00_0000;
  endproperty
  a_byte_upper: assert property (p_byte_upper) else $error("byte read upper bits set");

  property p_lsb_dw2;
    rd && addr == sfpt_pkg::OFF_BYTE_DATA && state_reg.ptr == 8'h07
      |=> rdata[7:0] == 8'h3F;
  endproperty
  a_lsb_dw2: assert property (p_lsb_dw2) else $error("density byte order wrong");

  property p_dual_stream;
    rd && addr == sfpt_pkg::OFF_BYTE_DATA && state_reg.ptr == 8'h0F
      |=> rdata[7:0] == 8'hBB;
  endproperty
  a_dual_stream: assert property (p_dual_stream) else $error("dual opcode byte wrong");

  // Expected stream built from constants, not from the read mux
  localparam int TABLE_BYTES_N = 20;
  localparam logic [159:0] TABLE_BYTES = {sfpt_pkg::DW5_VAL, sfpt_pkg::DW4_VAL, sfpt_pkg::DW3_VAL,
    sfpt_pkg::DW2_VAL, sfpt_pkg::DW1_BASE | (32'(DDR_SUPPORTED) << sfpt_pkg::DW1_DDR_BIT)};

  for (genvar g = 0; g < TABLE_BYTES_N; g++)
  begin : g_stream
    property p_stream_byte;
      rd && addr == sfpt_pkg::OFF_BYTE_DATA && state_reg.ptr == 8'(g)
        |=> rdata == {24'h00_0000, TABLE_BYTES[8*g +: 8]};
    endproperty
    a_stream_byte: assert property (p_stream_byte) else $error("stream byte wrong");
  end

endmodule

`default_nettype wire

// ---- dv/sfpt_host.sv ----
// Host controller model that reads the parameter table
`timescale 1ns/100ps
`default_nettype none
module sfpt_host (
  input wire logic clock,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  initial
  begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ---- dv/test_sfpt_table.sv ----
// Self-checking bench for the serial flash parameter table
`timescale 1ns/100ps
`default_nettype none
module test_sfpt_table;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [7:0] starts [3];
  logic [31:0] dw [5] = '{32'hFFBA_FFE7, 32'h3FFF_FFFF, 32'hFFFF_EB48, 32'hBB88_FFFF, 32'hFFFF_FFFE};
  int n_fail = 0;
  int total_checks = 0;
  always #2 clock = ~clock;
  sfpt_table #(.DDR_SUPPORTED(1'b1)) dut_u (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  sfpt_host host_u (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  // Bytes beyond the five dwords read as all ones
  function automatic logic [31:0] exp_byte(input int n);
    if (n < 20)
      return (dw[n / 4] >> (8 * (n % 4))) & 32'h0000_00FF;
    return 32'h0000_00FF;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #50000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(88966));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    host_u.wr_reg(8'h00, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      host_u.rd_reg(8'(4 * i), got);
      check(got, dw[i]);
    end
    host_u.rd_reg(8'h10, got);
    check(got, 32'h0000_00FE);
    host_u.rd_reg(8'h14, got);
    check(got, 32'h0000_80A5);
    host_u.rd_reg(8'h30, got);
    check(got, 32'h0000_0000);
    @(posedge clock);
    #1;
    check(rdata, 32'h0000_0000);
    $display("register view test done");
    starts = '{8'h00, 8'($urandom_range(1, 19)), 8'hFE};
    for (int j = 0; j < 3; j++)
    begin
      host_u.wr_reg(8'h20, {24'h00_0000, starts[j]});
      host_u.rd_reg(8'h20, got);
      check(got, {24'h00_0000, starts[j]});
      host_u.rd_reg(8'h28, got);
      check(got, 32'(starts[j]) + 32'h0000_0002);
      host_u.rd_reg(8'h2C, got);
      check(got, 32'(starts[j]) + 32'h0000_1090);
      // Back to back strobes stress the pointer advance
      for (int k = 0; k < 24; k++)
      begin
        host_u.rd_reg(8'h24, got);
        check(got, exp_byte((int'(starts[j]) + k) % 256));
      end
      $display("byte stream test from %0d done", starts[j]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
